// ===== pecq_core_qualifier.sv
// How it works
// RQ1: Generic events (code 2E) count only while core runs non-halt code or is snooped.
// RQ2: A halted core being snooped still counts as active.
// RQ3: Unhalted cycle events never advance while halted, even when snooped.
// RQ4: Event code 3C picks one of three cycle units by unit mask.
// RQ5: Unit mask bits 15:14 select this-core or any-core counting.
// RQ6: Core-specificity value 11 counts the condition from all cores.
// RQ7: Bus data-ready with unit mask 20 counts every bus agent.
// RQ8: Shared-subsystem events qualify at processor or bus agent boundary.
// RQ9: One selection register only; no parallel per-processor bus counting.
// RQ10: Processor-independent events ignore the qualification field.
// RQ11: Unit mask 00 counts core clocks while not halted.
// RQ12: Unit mask 01 counts bus clock enables while not halted.
// RQ13: Counter adds one per qualifying cycle or occurrence.
`timescale 1ns/1ps
`include "pecq_params.svh"

module pecq_core_qualifier
    import pecq_pkg::*;
#(
    parameter int CNT_W = 40
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // Register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Core state from the core, same clock
    input  wire logic        core_halted_in,
    input  wire logic        core_snooped_in,
    input  wire logic        other_core_halted_in,
    input  wire logic        bus_clk_en_in,
    // Event occurrences, same clock
    input  wire logic        evt_this_core_in,
    input  wire logic        evt_other_core_in,
    input  wire logic        evt_other_agent_in,
    input  wire logic        bus_drdy_this_in,
    input  wire logic        bus_drdy_other_in,
    input  wire logic        indep_evt_in,
    // Status
    output logic             core_active_out,
    output logic             count_pulse_out
);

    // Register state
    logic [31:0]      evtsel_reg;
    logic [31:0]      evtsel_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [31:0]      rdata_next;
    logic [31:0]      status_word;
    // Selection fields
    logic [7:0]       evt_code;
    logic [7:0]       umask;
    logic [1:0]       corespec;
    logic             enable;
    pecq_scope_t      scope;
    // Activity and the selected occurrence
    logic             active;
    logic             unhalted;
    logic             hit;
    logic             count_loaded;
    logic             count_step;
    // Register port decode
    logic             wr_evtsel;
    logic             wr_count_lo;
    logic             wr_count_hi;
    // Per-unit qualified occurrences
    logic             core_cyc_hit;
    logic             ref_cyc_hit;
    logic             bus_cyc_hit;
    logic             cyc_hit;
    logic             drdy_hit;
    logic             indep_hit;
    logic             generic_hit;
    // Generic event sources: this core, other core, other agent
    logic [2:0]       src_evt;
    logic [2:0]       src_allow;
    logic [2:0]       src_hit;

    // Field extraction
    assign evt_code = evtsel_reg[`PECQ_EVT_MSB:`PECQ_EVT_LSB];
    assign umask    = evtsel_reg[`PECQ_UMASK_MSB:`PECQ_UMASK_LSB];
    assign corespec = evtsel_reg[`PECQ_CORESPEC_MSB:`PECQ_CORESPEC_LSB];
    assign enable   = evtsel_reg[`PECQ_EN_BIT];

    // Register write decode
    assign wr_evtsel   = reg_wr_in && (reg_addr_in == `PECQ_ADDR_EVTSEL);
    assign wr_count_lo = reg_wr_in && (reg_addr_in == `PECQ_ADDR_COUNT_LO);
    assign wr_count_hi = reg_wr_in && (reg_addr_in == `PECQ_ADDR_COUNT_HI);
    // Write or clear overrides the increment in the same cycle
    assign count_loaded = evtsel_reg[`PECQ_CLR_BIT] || wr_count_lo || wr_count_hi;
    assign count_step   = enable && hit && !count_loaded;              // [RQ13]

    // Activity qualification
    assign unhalted = !core_halted_in;                                  // [RQ3]
    assign active   = unhalted || core_snooped_in;                      // [RQ1] [RQ2]

    // Scope from the core-specificity field
    always_comb begin
        unique case (corespec)
            `PECQ_CS_THIS_CORE: begin
                scope = PECQ_SCOPE_THIS;                                // [RQ5]
            end
            `PECQ_CS_ALL_CORES: begin
                scope = PECQ_SCOPE_AGENTS;                              // [RQ6] [RQ8]
            end
            default: begin
                scope = PECQ_SCOPE_ALL;                                 // [RQ5]
            end
        endcase
    end

    // Cycle units; snooping never makes a halted core count here
    always_comb begin
        core_cyc_hit = unhalted;                                        // [RQ11] [RQ3]
        ref_cyc_hit  = unhalted && bus_clk_en_in;                       // [RQ12] [RQ3]
        bus_cyc_hit  = unhalted && bus_clk_en_in && other_core_halted_in; // [RQ3]
    end

    // One of three cycle units chosen by unit mask
    always_comb begin
        cyc_hit = 1'b0;
        unique case (umask)
            `PECQ_UM_CORE_CYC: begin
                cyc_hit = core_cyc_hit;                                 // [RQ4]
            end
            `PECQ_UM_REF_CYC: begin
                cyc_hit = ref_cyc_hit;                                  // [RQ4]
            end
            `PECQ_UM_BUS_CYC: begin
                cyc_hit = bus_cyc_hit;                                  // [RQ4]
            end
            default: begin
                cyc_hit = 1'b0;
            end
        endcase
    end

    // Data-ready occurrences; processor field bits 15:14 are part of the unit mask compared with 20
    always_comb begin
        if (umask == `PECQ_UM_ALL_AGENTS) begin
            drdy_hit = bus_drdy_this_in || bus_drdy_other_in;           // [RQ7] [RQ10]
        end else begin
            drdy_hit = bus_drdy_this_in;                                // [RQ10]
        end
    end

    // Processor-independent occurrence
    assign indep_hit = indep_evt_in;                                    // [RQ10]

    // Generic occurrence sources
    assign src_evt = {evt_other_agent_in, evt_other_core_in, evt_this_core_in};

    // Sources admitted by the counting scope
    always_comb begin
        unique case (scope)
            PECQ_SCOPE_THIS: begin
                src_allow = `PECQ_SRC_THIS;                             // [RQ5]
            end
            PECQ_SCOPE_ALL: begin
                src_allow = `PECQ_SRC_CORES;                            // [RQ5]
            end
            PECQ_SCOPE_AGENTS: begin
                src_allow = `PECQ_SRC_AGENTS;                           // [RQ6] [RQ8]
            end
            default: begin
                src_allow = `PECQ_SRC_NONE;
            end
        endcase
    end

    // Each source qualified by scope and core activity
    generate
        for (genvar src_idx = 0; src_idx < `PECQ_NUM_SRC; src_idx = src_idx + 1) begin : g_src
            assign src_hit[src_idx] = active && src_evt[src_idx] && src_allow[src_idx]; // [RQ1]
        end
    endgenerate
    assign generic_hit = |src_hit;                                      // [RQ13]

    // Event code selects the qualified occurrence
    always_comb begin
        hit = 1'b0;
        unique case (evt_code)
            `PECQ_EVT_CYCLES: begin
                hit = cyc_hit;                                          // [RQ4]
            end
            `PECQ_EVT_BUS_DRDY: begin
                hit = drdy_hit;                                         // [RQ7]
            end
            `PECQ_EVT_INDEP: begin
                hit = indep_hit;                                        // [RQ10]
            end
            `PECQ_EVT_GENERIC: begin
                hit = generic_hit;                                      // [RQ1]
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Counter next value
    always_comb begin
        count_next = count_reg;
        if (enable && hit) begin
            count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};           // [RQ13]
        end
    end

    // Selection register next value; clear bit lasts one cycle
    always_comb begin
        evtsel_next = evtsel_reg;
        evtsel_next[`PECQ_CLR_BIT] = 1'b0;
        if (wr_evtsel) begin
            evtsel_next = reg_wdata_in & `PECQ_EVTSEL_MASK;             // [RQ9]
        end
    end

    // Single event selection register
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            evtsel_reg <= `PECQ_EVTSEL_RST;
        end else begin
            evtsel_reg <= evtsel_next;
        end
    end

    // Counter; software write or clear bit preloads it
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= '0;
        end else if (evtsel_reg[`PECQ_CLR_BIT]) begin
            count_reg <= '0;
        end else if (wr_count_lo) begin
            count_reg <= {count_reg[CNT_W-1:`PECQ_WORD_W], reg_wdata_in};
        end else if (wr_count_hi) begin
            count_reg <= {reg_wdata_in[CNT_W-`PECQ_WORD_W-1:0], count_reg[`PECQ_WORD_W-1:0]};
        end else begin
            count_reg <= count_next;                                    // [RQ13]
        end
    end

    // Registered activity flag
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            core_active_out <= 1'b0;
        end else begin
            core_active_out <= active;                                  // [RQ1]
        end
    end

    // Pulse only when the counter really advanced
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_pulse_out <= 1'b0;
        end else begin
            count_pulse_out <= count_step;                              // [RQ13]
        end
    end

    // Status word: snoop, halt and activity levels
    always_comb begin
        status_word                          = `PECQ_WORD_ZERO;
        status_word[`PECQ_STAT_ACTIVE_BIT]   = active;                  // [RQ1]
        status_word[`PECQ_STAT_HALTED_BIT]   = core_halted_in;
        status_word[`PECQ_STAT_SNOOPED_BIT]  = core_snooped_in;         // [RQ2]
    end

    // Read word by index; unmapped indices and idle cycles read zero
    always_comb begin
        rdata_next = `PECQ_WORD_ZERO;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `PECQ_ADDR_EVTSEL: begin
                    rdata_next = evtsel_reg;
                end
                `PECQ_ADDR_COUNT_LO: begin
                    rdata_next = count_reg[`PECQ_WORD_W-1:0];
                end
                `PECQ_ADDR_COUNT_HI: begin
                    rdata_next = 32'(count_reg[CNT_W-1:`PECQ_WORD_W]);
                end
                `PECQ_ADDR_STATUS: begin
                    rdata_next = status_word;
                end
                `PECQ_ADDR_ID: begin
                    rdata_next = `PECQ_ID_VALUE;                        // Arbitrary value
                end
                default: begin
                    rdata_next = `PECQ_WORD_ZERO;
                end
            endcase
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= `PECQ_WORD_ZERO;
        end else begin
            reg_rdata_out <= rdata_next;
        end
    end

endmodule : pecq_core_qualifier

// ===== pecq_params.svh
`ifndef PECQ_PARAMS_SVH
`define PECQ_PARAMS_SVH

// Register indices on the plain register port
`define PECQ_ADDR_EVTSEL   4'h0
`define PECQ_ADDR_COUNT_LO 4'h1
`define PECQ_ADDR_COUNT_HI 4'h2
`define PECQ_ADDR_STATUS   4'h3
`define PECQ_ADDR_ID       4'h4

// Event selection register fields
`define PECQ_EVT_LSB       0
`define PECQ_EVT_MSB       7
`define PECQ_UMASK_LSB     8
`define PECQ_UMASK_MSB     15
`define PECQ_CORESPEC_LSB  14
`define PECQ_CORESPEC_MSB  15
`define PECQ_EN_BIT        22
`define PECQ_CLR_BIT       23
`define PECQ_EVTSEL_RST    32'h0000_0000
`define PECQ_EVTSEL_MASK   32'h00c0_ffff

// Event codes and unit masks
`define PECQ_EVT_CYCLES    8'h3c
`define PECQ_EVT_BUS_DRDY  8'h62
`define PECQ_EVT_GENERIC   8'h2e
`define PECQ_EVT_INDEP     8'h07
`define PECQ_UM_CORE_CYC   8'h00
`define PECQ_UM_REF_CYC    8'h01
`define PECQ_UM_BUS_CYC    8'h02
`define PECQ_UM_ALL_AGENTS 8'h20
`define PECQ_CS_ALL_CORES  2'h3
`define PECQ_CS_THIS_CORE  2'h0

// Sources admitted per scope
`define PECQ_NUM_SRC       3
`define PECQ_SRC_THIS      3'h1
`define PECQ_SRC_CORES     3'h3
`define PECQ_SRC_AGENTS    3'h7
`define PECQ_SRC_NONE      3'h0

// Register word layout
`define PECQ_WORD_W        32
`define PECQ_WORD_ZERO     32'h0000_0000
`define PECQ_STAT_ACTIVE_BIT  0
`define PECQ_STAT_HALTED_BIT  1
`define PECQ_STAT_SNOOPED_BIT 2

`define PECQ_ID_VALUE      32'h0000_5a01

`endif

// ===== pecq_pkg.sv
package pecq_pkg;
    // Counting scope chosen by unit mask
    typedef enum logic [1:0] {
        PECQ_SCOPE_THIS   = 2'h0,
        PECQ_SCOPE_ALL    = 2'h1,
        PECQ_SCOPE_AGENTS = 2'h3
    } pecq_scope_t;
endpackage : pecq_pkg

// ===== pecq_properties.sv
`timescale 1ns/1ps
`include "pecq_params.svh"
module pecq_checker (
    // Clock, reset and register writes
    input wire logic        clock_in, rst_n_in, reg_wr_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    // Core state and events
    input wire logic        core_halted_in, core_snooped_in, bus_clk_en_in,
    input wire logic        evt_other_agent_in, bus_drdy_other_in, indep_evt_in,
    // Status outputs
    input wire logic        core_active_out, count_pulse_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    logic [31:0] sel_reg;
    // Shadow of the selection register
    always_ff @(posedge clock_in or negedge rst_n_in)
        if (!rst_n_in) sel_reg <= 32'h0;
        else if (reg_wr_in && reg_addr_in == `PECQ_ADDR_EVTSEL) sel_reg <= reg_wdata_in & `PECQ_EVTSEL_MASK;
    wire on = sel_reg[22] && !reg_wr_in;
    wire [7:0] ev = sel_reg[7:0];
    wire [7:0] um = sel_reg[15:8];
    act_follow_a: assert property (rst_n_in |=> core_active_out == $past(!core_halted_in || core_snooped_in))
        else $error("active flag wrong");
    snoop_act_a: assert property (core_halted_in && core_snooped_in |=> core_active_out)
        else $error("snooped halt not active");
    halt_nocyc_a: assert property (on && ev == 8'h3c && core_halted_in |=> !count_pulse_out)
        else $error("cycle count while halted");
    core_cyc_a: assert property (on && ev == 8'h3c && um == 8'h00 && !core_halted_in |=> count_pulse_out)
        else $error("core cycle missed");
    ref_cyc_a: assert property (on && ev == 8'h3c && um == 8'h01 && !core_halted_in
        |=> count_pulse_out == $past(bus_clk_en_in)) else $error("ref cycle wrong");
    bus_cyc_a: assert property (on && ev == 8'h3c && um == 8'h02 && !bus_clk_en_in |=> !count_pulse_out)
        else $error("bus cycle off bus clock");
    drdy_all_a: assert property (on && ev == 8'h62 && um == 8'h20 && bus_drdy_other_in |=> count_pulse_out)
        else $error("agent data ready missed");
    indep_cnt_a: assert property (on && ev == 8'h07 |=> count_pulse_out == $past(indep_evt_in))
        else $error("independent event wrong");
    agent_all_a: assert property (on && ev == 8'h2e && sel_reg[15:14] == 2'h3 && !core_halted_in
        && evt_other_agent_in |=> count_pulse_out) else $error("all-core scope missed");
    cover property (on && ev == 8'h3c ##1 count_pulse_out);
    cover property (core_halted_in && core_snooped_in ##1 core_active_out);
    cover property (on && ev == 8'h2e ##1 count_pulse_out);
endmodule : pecq_checker
bind pecq_core_qualifier pecq_checker u_chk (.*);

// ===== tb_pecq_core_qualifier.sv
`timescale 1ns/1ps
`include "pecq_params.svh"
module tb_pecq_core_qualifier;
    logic        clock_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [3:0]  reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
    logic [9:0]  stim = 10'h0;
    logic        core_active_out, count_pulse_out;
    int          fail_count = 0, n_checks = 0;
    wire logic core_halted_in, core_snooped_in, other_core_halted_in, bus_clk_en_in,
        evt_this_core_in, evt_other_core_in, evt_other_agent_in, bus_drdy_this_in,
        bus_drdy_other_in, indep_evt_in;
    // Core and event levels from one vector
    assign {core_halted_in, core_snooped_in, other_core_halted_in, bus_clk_en_in,
        evt_this_core_in, evt_other_core_in, evt_other_agent_in, bus_drdy_this_in,
        bus_drdy_other_in, indep_evt_in} = stim;
    always #10 clock_in = ~clock_in;
    pecq_core_qualifier dut (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, e);
    endtask : rd
    // Count n qualifying cycles under one selection, then read the total
    task automatic run(input logic [9:0] s, input logic [31:0] sel, input int n,
                       input logic [31:0] e);
        wr(`PECQ_ADDR_COUNT_LO, 32'h0);
        wr(`PECQ_ADDR_COUNT_HI, 32'h0);
        stim <= s;
        wr(`PECQ_ADDR_EVTSEL, sel);
        repeat (n - 2) @(posedge clock_in);
        #1 chk({31'h0, count_pulse_out}, {31'h0, e != 32'h0});
        wr(`PECQ_ADDR_EVTSEL, 32'h0);
        rd(`PECQ_ADDR_COUNT_LO, e);
    endtask : run
    task automatic reg_scn();
        rd(`PECQ_ADDR_EVTSEL, `PECQ_EVTSEL_RST);
        wr(`PECQ_ADDR_EVTSEL, 32'hffff_ffff);
        rd(`PECQ_ADDR_EVTSEL, 32'h0040_ffff);
        wr(`PECQ_ADDR_ID, 32'h0);
        rd(`PECQ_ADDR_ID, `PECQ_ID_VALUE);
        rd(4'hf, 32'h0);
        wr(`PECQ_ADDR_COUNT_HI, 32'h0000_00ab);
        rd(`PECQ_ADDR_COUNT_HI, 32'h0000_00ab);
        wr(`PECQ_ADDR_EVTSEL, 32'h0080_0000);
        rd(`PECQ_ADDR_COUNT_HI, 32'h0);
    endtask : reg_scn
    task automatic cyc_scn();
        run(10'h000, 32'h0040_003c, 5, 32'h5);
        run(10'h300, 32'h0040_003c, 5, 32'h0);
        run(10'h040, 32'h0040_013c, 4, 32'h4);
        run(10'h000, 32'h0040_013c, 4, 32'h0);
        run(10'h0c0, 32'h0040_023c, 3, 32'h3);
        run(10'h080, 32'h0040_023c, 3, 32'h0);
    endtask : cyc_scn
    task automatic bus_scn();
        run(10'h002, 32'h0040_2062, 4, 32'h4);
        run(10'h002, 32'h0040_0062, 4, 32'h0);
        run(10'h004, 32'h0040_c062, 3, 32'h3);
        run(10'h201, 32'h0040_c007, 3, 32'h3);
    endtask : bus_scn
    task automatic scope_scn();
        run(10'h010, 32'h0040_002e, 3, 32'h0);
        run(10'h010, 32'h0040_402e, 3, 32'h3);
        run(10'h008, 32'h0040_c02e, 4, 32'h4);
        run(10'h008, 32'h0040_402e, 4, 32'h0);
        run(10'h320, 32'h0040_002e, 3, 32'h3);
        rd(`PECQ_ADDR_STATUS, 32'h7);
        chk({31'h0, core_active_out}, 32'h1);
        run(10'h220, 32'h0040_002e, 3, 32'h0);
        rd(`PECQ_ADDR_STATUS, 32'h2);
        chk({31'h0, core_active_out}, 32'h0);
    endtask : scope_scn
    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        reg_scn();
        cyc_scn();
        bus_scn();
        scope_scn();
        tally_and_finish();
    end
endmodule : tb_pecq_core_qualifier
